/* File: shared/adcocr_map.vh */
`ifndef ADCOCR_MAP_VH
`define ADCOCR_MAP_VH

// Register indices; the byte address is four times the index
`define ADCOCR_IDX_GAIN      8'h0C
`define ADCOCR_IDX_OUTCFG    8'h0D
`define ADCOCR_IDX_STATUS    8'h0E
`define ADCOCR_ADDR_GAIN     12'h030
`define ADCOCR_ADDR_OUTCFG   12'h034
`define ADCOCR_ADDR_STATUS   12'h038

// Field positions, gain register
`define ADCOCR_GAIN_MSB      10
`define ADCOCR_GAIN_LSB      8
`define ADCOCR_PATH_MSB      2
`define ADCOCR_PATH_LSB      0

// Field positions, output interface register
`define ADCOCR_B_TWOWIRE     0
`define ADCOCR_B_SDR         1
`define ADCOCR_B_SER16       2
`define ADCOCR_B_RISE        4
`define ADCOCR_B_COARSE      5
`define ADCOCR_B_LSBFIRST    6
`define ADCOCR_B_BITWISE     7
`define ADCOCR_B_OVRD        10

// Writable bit masks and reset values
`define ADCOCR_GAIN_MASK     11'h707
`define ADCOCR_OUTCFG_MASK   11'h4F7
`define ADCOCR_RESET_VAL     11'h000
// Effective settings after reset: everything off, launch on the rising edge
`define ADCOCR_EFF_RESET     8'h10

// Fine gain limits, in dB per code step
`define ADCOCR_GAIN_MAX      3'h6

// Pin synchroniser width: seven control pins plus the link clock
`define ADCOCR_SYNC_W        8

`endif

/* File: rtl/adcocr_sync.v */
`timescale 1ns/10ps
// Three-stage synchroniser; a bit changes once stages two and three agree
module adcocr_sync #(
  parameter W = 8
) (
  input  wire         MCLK,
  input  wire         RST,
  input  wire [W-1:0] D_IN,
  output wire [W-1:0] Q_OUT
);
  reg [W-1:0] s1_ff;
  reg [W-1:0] s2_ff;
  reg [W-1:0] s3_ff;
  reg [W-1:0] q_ff;

  assign Q_OUT = q_ff;

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      // Stage chain and agreement filter per bit
      always @(posedge MCLK) begin
        if (RST) begin
          s1_ff[i] <= 1'b0;
          s2_ff[i] <= 1'b0;
          s3_ff[i] <= 1'b0;
          q_ff[i]  <= 1'b0;
        end else begin
          s1_ff[i] <= D_IN[i];
          s2_ff[i] <= s1_ff[i];
          s3_ff[i] <= s2_ff[i];
          if (s2_ff[i] == s3_ff[i]) begin
            q_ff[i] <= s3_ff[i];
          end
        end
      end
    end
  endgenerate
endmodule // adcocr_sync

/* File: rtl/adcocr_top.v */
`timescale 1ns/10ps
`include "adcocr_map.vh"

// What this block does
// - Gain register: fine gain D10-D8, pattern D2-D0
// - Fine gain code steps 1 dB, max 6
// - Both registers clear on hard/soft reset
// - D0 selects one-lane or two-lane output
// - D1 selects SDR clock, two-wire only
// - D2 selects 14 or 16 bit serialization
// - D4 capture edge, applies only in SDR
// - Data launched opposite the chosen capture edge
// - D5 enables 3.5 dB coarse gain
// - D6 selects MSB or LSB first
// - D7 byte or bit split, two-wire only
// - D10 makes register override control pins
module adcocr_top (
  input  wire        MCLK,
  input  wire        RST,
  input  wire        SOFT_RST,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  output wire [31:0] PRDATA,
  output wire        PREADY,
  output wire        PSLVERR,
  input  wire        PIN_TWO_WIRE,
  input  wire        PIN_SDR,
  input  wire        PIN_SER16,
  input  wire        PIN_RISE_EDGE,
  input  wire        PIN_COARSE,
  input  wire        PIN_LSB_FIRST,
  input  wire        PIN_BIT_WISE,
  input  wire        LINK_CLK,
  output wire        TWO_WIRE,
  output wire        SDR_CLK,
  output wire        SER16,
  output wire        CAPTURE_RISE,
  output wire        LAUNCH_RISE,
  output wire        COARSE_GAIN,
  output wire        LSB_FIRST,
  output wire        BIT_WISE,
  output wire [2:0]  FINE_GAIN_DB,
  output wire [2:0]  PATTERN_HIGH
);
  reg  [10:0] gain_reg_ff;
  reg  [10:0] ocfg_reg_ff;
  reg  [31:0] rdata_ff;
  reg  [7:0]  eff_ff;
  reg  [2:0]  fine_ff;
  reg  [2:0]  path_ff;
  reg         link_prev_ff;
  reg  [7:0]  nxt_eff;
  reg  [2:0]  nxt_fine;
  reg  [31:0] nxt_rdata;
  wire [7:0]  pins_sync;
  wire        link_s;
  wire        link_rise;
  wire        setup;
  wire        access_wr;
  wire [6:0]  src;
  wire        two_wire_sel;
  wire        sdr_sel;

  // Address decode used by the error logic; reads decode the address in their own case
  function addr_hit;
    input [11:0] a;
    begin
      addr_hit = (a == `ADCOCR_ADDR_GAIN) || (a == `ADCOCR_ADDR_OUTCFG) || (a == `ADCOCR_ADDR_STATUS);
    end
  endfunction

  // Control pins and link clock cross through the synchroniser
  adcocr_sync #(
    .W (`ADCOCR_SYNC_W)
  ) u_sync (
    .MCLK  (MCLK),
    .RST   (RST),
    .D_IN  ({LINK_CLK, PIN_BIT_WISE, PIN_LSB_FIRST, PIN_COARSE, PIN_RISE_EDGE, PIN_SER16, PIN_SDR, PIN_TWO_WIRE}),
    .Q_OUT (pins_sync)
  );

  assign link_s    = pins_sync[7];
  assign link_rise = link_s & ~link_prev_ff;

  // APB slave: zero wait states, error on unmapped address
  assign setup     = PSEL & ~PENABLE;
  assign access_wr = PSEL & PENABLE & PWRITE;
  assign PREADY    = 1'b1;
  assign PSLVERR   = PSEL & PENABLE & ~addr_hit(PADDR);
  assign PRDATA    = rdata_ff;

  // Register writes; unused bits are kept at zero
  always @(posedge MCLK) begin
    if (RST || SOFT_RST) begin
      gain_reg_ff <= `ADCOCR_RESET_VAL;
      ocfg_reg_ff <= `ADCOCR_RESET_VAL;
    end else if (access_wr) begin
      if (PADDR == `ADCOCR_ADDR_GAIN) begin
        gain_reg_ff <= PWDATA[10:0] & `ADCOCR_GAIN_MASK;
      end
      if (PADDR == `ADCOCR_ADDR_OUTCFG) begin
        ocfg_reg_ff <= PWDATA[10:0] & `ADCOCR_OUTCFG_MASK;
      end
    end
  end

  // Read data captured in the setup cycle, valid in the access phase
  always @* begin
    nxt_rdata = rdata_ff;
    if (setup && !PWRITE) begin
      case (PADDR)
        `ADCOCR_ADDR_GAIN: begin
          nxt_rdata = {21'h00_0000, gain_reg_ff};
        end
        `ADCOCR_ADDR_OUTCFG: begin
          nxt_rdata = {21'h00_0000, ocfg_reg_ff};
        end
        `ADCOCR_ADDR_STATUS: begin
          nxt_rdata = {18'h0_0000, fine_ff, path_ff, eff_ff};
        end
        default: begin
          nxt_rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always @(posedge MCLK) begin
    if (RST) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Register settings win over the pins when override is set
  assign src = ocfg_reg_ff[`ADCOCR_B_OVRD] ?
               {ocfg_reg_ff[7:4], ocfg_reg_ff[2:0]} : pins_sync[6:0];
  assign two_wire_sel = src[0];
  assign sdr_sel      = src[1] & two_wire_sel;

  // Effective configuration, with mode qualifications applied
  always @* begin
    nxt_eff    = 8'h00;
    nxt_eff[0] = two_wire_sel;
    nxt_eff[1] = sdr_sel;
    nxt_eff[2] = src[2];
    nxt_eff[3] = sdr_sel & src[3];
    nxt_eff[4] = ~(sdr_sel & src[3]);
    nxt_eff[5] = src[4];
    nxt_eff[6] = src[5];
    nxt_eff[7] = two_wire_sel & src[6];
    nxt_fine   = gain_reg_ff[`ADCOCR_GAIN_MSB:`ADCOCR_GAIN_LSB];
    if (nxt_fine > `ADCOCR_GAIN_MAX) begin
      nxt_fine = `ADCOCR_GAIN_MAX;
    end
  end

  // Settings reach the lanes only at a link clock rising edge
  always @(posedge MCLK) begin
    if (RST) begin
      eff_ff       <= `ADCOCR_EFF_RESET;
      fine_ff      <= 3'h0;
      path_ff      <= 3'h0;
      link_prev_ff <= 1'b0;
    end else begin
      link_prev_ff <= link_s;
      if (link_rise) begin
        eff_ff  <= nxt_eff;
        fine_ff <= nxt_fine;
        path_ff <= gain_reg_ff[`ADCOCR_PATH_MSB:`ADCOCR_PATH_LSB];
      end
    end
  end

  assign TWO_WIRE     = eff_ff[0];
  assign SDR_CLK      = eff_ff[1];
  assign SER16        = eff_ff[2];
  assign CAPTURE_RISE = eff_ff[3];
  assign LAUNCH_RISE  = eff_ff[4];
  assign COARSE_GAIN  = eff_ff[5];
  assign LSB_FIRST    = eff_ff[6];
  assign BIT_WISE     = eff_ff[7];
  assign FINE_GAIN_DB = fine_ff;
  assign PATTERN_HIGH = path_ff;
endmodule // adcocr_top

/* File: test/adcocr_link.sv */
`timescale 1ns/10ps
// Free-running bit clock of the link, phase unrelated to MCLK
module adcocr_link (
  output logic LINK_CLK
);
  // Offset start, then 48 ns period
  initial begin
    LINK_CLK = 1'b0;
    #7;
    forever #24 LINK_CLK = ~LINK_CLK;
  end
endmodule // adcocr_link

/* File: test/adcocr_top_assertions.sv */
`timescale 1ns/10ps
module adcocr_chk (
  input wire logic        MCLK,
  input wire logic        RST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic [11:0] PADDR,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        TWO_WIRE,
  input wire logic        SDR_CLK,
  input wire logic        SER16,
  input wire logic        CAPTURE_RISE,
  input wire logic        LAUNCH_RISE,
  input wire logic        BIT_WISE,
  input wire logic [2:0]  FINE_GAIN_DB
);
  // All checks on the bus clock
  default clocking cb @(posedge MCLK); endclocking
  a_ready_high: assert property (disable iff (RST) PREADY) else $error("pready low");
  a_launch_opp: assert property (disable iff (RST) LAUNCH_RISE != CAPTURE_RISE) else $error("edges");
  a_gain_max: assert property (disable iff (RST) FINE_GAIN_DB <= 3'h6) else $error("gain");
  a_sdr_two: assert property (disable iff (RST) SDR_CLK |-> TWO_WIRE) else $error("sdr");
  a_edge_sdr: assert property (disable iff (RST) CAPTURE_RISE |-> SDR_CLK) else $error("edge");
  a_split_two: assert property (disable iff (RST) BIT_WISE |-> TWO_WIRE) else $error("split");
  a_reset_clear: assert property (RST |=> !TWO_WIRE && !SER16 && LAUNCH_RISE && FINE_GAIN_DB == 3'h0)
    else $error("reset");
  a_err_map: assert property (disable iff (RST) PSEL && PENABLE |->
    PSLVERR == !(PADDR inside {12'h030, 12'h034, 12'h038})) else $error("slverr");
endmodule // adcocr_chk

/* File: test/tb.sv */
`timescale 1ns/10ps
module tb;
  logic        MCLK, RST, SOFT_RST, PSEL, PENABLE, PWRITE, LINK_CLK, PREADY, PSLVERR, e;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, q, seed;
  logic [6:0]  pins;
  logic [10:0] gw, cw;
  logic [13:0] outs;
  int          error_cnt, checked, n;
  adcocr_link i_adcocr_link (.LINK_CLK(LINK_CLK));
  adcocr_top i_adcocr_top (.MCLK(MCLK), .RST(RST), .SOFT_RST(SOFT_RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .PIN_TWO_WIRE(pins[0]), .PIN_SDR(pins[1]), .PIN_SER16(pins[2]), .PIN_RISE_EDGE(pins[3]),
    .PIN_COARSE(pins[4]), .PIN_LSB_FIRST(pins[5]), .PIN_BIT_WISE(pins[6]), .LINK_CLK(LINK_CLK),
    .TWO_WIRE(outs[0]), .SDR_CLK(outs[1]), .SER16(outs[2]), .CAPTURE_RISE(outs[3]), .LAUNCH_RISE(outs[4]),
    .COARSE_GAIN(outs[5]), .LSB_FIRST(outs[6]), .BIT_WISE(outs[7]), .PATTERN_HIGH(outs[10:8]),
    .FINE_GAIN_DB(outs[13:11]));
  // Clock, 5 ns period
  initial begin
    MCLK = 1'b0;
    forever #2.5 MCLK = ~MCLK;
  end
  function logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // Effective config, register or pins as source
  function logic [13:0] expect_cfg(input logic [10:0] g, c, input logic [6:0] p);
    logic [6:0] s;
    logic       t, d, r;
    s = c[10] ? {c[7:4], c[2:0]} : p;
    t = s[0];
    d = s[1] & t;
    r = s[3] & d;
    return {(g[10:8] > 3'h6) ? 3'h6 : g[10:8], g[2:0], s[6] & t, s[5], s[4], ~r, r, s[2], d, t};
  endfunction
  task report_and_stop;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready is sampled
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge MCLK);
    PSEL <= 1'b1; PWRITE <= w; PADDR <= a; PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin @(posedge MCLK); n++; end while (PREADY !== 1'b1 && n < 20);
    q = PRDATA; e = PSLVERR;
    PSEL <= 1'b0; PENABLE <= 1'b0;
    if (n >= 20) begin chk(0, 1); report_and_stop; end
  endtask
  // Wait for the outputs to follow a link edge, sampled mid-cycle, bounded
  task wait_out(input logic [13:0] x);
    n = 0;
    do begin @(negedge MCLK); n++; end while (outs !== x && n < 60);
    chk(32'(outs), 32'(x));
    if (outs !== x) report_and_stop;
  endtask
  // Main sequence
  initial begin
    RST = 1'b1; SOFT_RST = 1'b0; PSEL = 1'b0; PENABLE = 1'b0; PWRITE = 1'b0; PADDR = 0; PWDATA = 0;
    pins = 0; seed = 32'h0000_91eb; error_cnt = 0; checked = 0;
    repeat (16) @(posedge MCLK);
    RST <= 1'b0;
    apb(0, 12'h030, 0); chk(q, 0);
    apb(0, 12'h034, 0); chk(q, 0);
    for (int i = 0; i < 40; i++) begin
      seed = xs(seed);
      gw = seed[10:0] & 11'h707;
      if (i < 7) gw[10:8] = 3'(i);
      if (gw[10:8] == 3'h7) gw[10:8] = 3'h6;
      cw = seed[26:16] & 11'h4f7;
      pins <= seed[6:0] ^ seed[31:25];
      apb(1, 12'h030, {21'h0, gw});
      apb(1, 12'h034, {21'h0, cw});
      apb(0, 12'h030, 0); chk(q, {21'h0, gw});
      apb(0, 12'h034, 0); chk(q, {21'h0, cw});
      wait_out(expect_cfg(gw, cw, pins));
      apb(0, 12'h038, 0); chk(q, {18'h0, expect_cfg(gw, cw, pins)});
    end
    apb(1, 12'h03c, 32'hffff_ffff); chk(e, 1);
    apb(0, 12'h034, 0); chk(q, {21'h0, cw});
    apb(0, 12'h03c, 0); chk(q, 0);
    SOFT_RST <= 1'b1;
    @(posedge MCLK);
    SOFT_RST <= 1'b0;
    apb(0, 12'h030, 0); chk(q, 0);
    apb(0, 12'h034, 0); chk(q, 0);
    wait_out(expect_cfg(0, 0, pins));
    report_and_stop;
  end
endmodule // tb
bind adcocr_top adcocr_chk i_adcocr_chk (.*);
